// ==== pdc_pkg.sv ====
// Constants, register map and state encodings for the power-down controller.
package pdc_pkg;

    localparam int CELLS  = 32;
    localparam int SIG_W  = 16;
    localparam int MEM_AW = 5;
    localparam int MEM_WORDS = 32;

    // ------------------------------------------------------------------
    // Register map (word indices; byte offset = index * 4)
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL      = 4'h0;
    localparam logic [3:0] IDX_STATUS    = 4'h1;
    localparam logic [3:0] IDX_LOW_POWER = 4'h2;
    localparam logic [3:0] IDX_SLEW_FAST = 4'h3;
    localparam logic [3:0] IDX_OUT_EN    = 4'h4;
    localparam logic [3:0] IDX_OUT_POL   = 4'h5;
    localparam logic [3:0] IDX_SIGNATURE = 4'h6;
    localparam logic [3:0] IDX_FUSE      = 4'h7;
    localparam logic [3:0] IDX_CFG_ADDR  = 4'h8;
    localparam logic [3:0] IDX_CFG_DATA  = 4'h9;
    localparam logic [3:0] IDX_NONE      = 4'hF;
    localparam logic [7:0] LAST_OFFSET   = 8'h24;

    localparam int CTRL_PD_EN  = 0;
    localparam int CTRL_USE_A  = 1;
    localparam int CTRL_USE_B  = 2;
    localparam int CTRL_W      = 3;
    localparam int ST_PD       = 0;
    localparam int ST_FUSE     = 1;
    localparam int ST_READY    = 2;
    localparam int ST_REFUSED  = 3;
    localparam int FUSE_PROG   = 0;
    localparam int PIN_A       = 0;
    localparam int PIN_B       = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS    = 4;
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W  = 7;

    // ------------------------------------------------------------------
    // Test access port
    // ------------------------------------------------------------------
    localparam int JT_TCK = 0;
    localparam int JT_TMS = 1;
    localparam int JT_TDI = 2;
    localparam logic [1:0] IR_SIG     = 2'h1;
    localparam logic [1:0] IR_VERIFY  = 2'h2;
    localparam logic [1:0] IR_BYPASS  = 2'h3;
    localparam logic [1:0] IR_CAPTURE = 2'h1;

    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAPTURE_DR = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAPTURE_IR = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } tap_state_t;

endpackage : pdc_pkg

// ==== cfg_mem.sv ====
// Configuration pattern store with a registered read port.
`timescale 1ns/1ps
module cfg_mem
(
    input  wire logic                      aclk,    // System clock.
    input  wire logic                      aresetn, // Sync reset, low.
    input  wire logic                      we,      // Write strobe.
    input  wire logic [pdc_pkg::MEM_AW-1:0] addr,   // Word address.
    input  wire logic [31:0]               wdata,   // Write data.
    output logic      [31:0]               rdata    // Registered read.
);
    import pdc_pkg::*;

    typedef struct packed {
        logic [MEM_WORDS-1:0][31:0] words;
        logic [31:0]                rdata;
    } mem_state_t;

    mem_state_t r;
    mem_state_t next_r;

    // Erased parts read back as all zeros.
    always_comb
    begin
        next_r = r;
        if (we)
        begin
            next_r.words[addr] = wdata;
        end
        next_r.rdata = r.words[addr];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;

endmodule : cfg_mem

// ==== power_down_and_config_control.sv ====
// Power-down, cell defaults, reset settling, fuse and JTAG access.
`timescale 1ns/1ps
module power_down_and_config_control
(
    input  wire logic                      aclk,     // System clock.
    input  wire logic                      aresetn,  // Sync reset, low.
    input  wire logic [7:0]                awaddr,   // AXI write address.
    input  wire logic                      awvalid,  // AXI.
    output logic                           awready,  // AXI.
    input  wire logic [31:0]               wdata,    // AXI write data.
    input  wire logic [3:0]                wstrb,    // AXI byte enables.
    input  wire logic                      wvalid,   // AXI.
    output logic                           wready,   // AXI.
    output logic [1:0]                     bresp,    // AXI.
    output logic                           bvalid,   // AXI.
    input  wire logic                      bready,   // AXI.
    input  wire logic [7:0]                araddr,   // AXI read address.
    input  wire logic                      arvalid,  // AXI.
    output logic                           arready,  // AXI.
    output logic [31:0]                    rdata,    // AXI read data.
    output logic [1:0]                     rresp,    // AXI.
    output logic                           rvalid,   // AXI.
    input  wire logic                      rready,   // AXI.
    input  wire logic [pdc_pkg::CELLS-1:0] io_in,    // Pins, async.
    output logic [pdc_pkg::CELLS-1:0]      io_out,   // Pin drive level.
    output logic [pdc_pkg::CELLS-1:0]      io_oe,    // Low drives pin.
    output logic [pdc_pkg::CELLS-1:0]      slew_fast,      // 1 fast edge.
    output logic [pdc_pkg::CELLS-1:0]      cell_low_power, // Per cell.
    output logic [pdc_pkg::CELLS-1:0]      logic_in, // Held inputs.
    input  wire logic [pdc_pkg::CELLS-1:0] core_d,   // Cell next values.
    output logic [pdc_pkg::CELLS-1:0]      buried_fb, // Cell feedback.
    output logic                           freeze,   // Powered down.
    input  wire logic                      tck,      // JTAG clock pin.
    input  wire logic                      tms,      // JTAG mode pin.
    input  wire logic                      tdi,      // JTAG data in.
    output logic                           tdo_out,  // JTAG data out.
    output logic                           tdo_oe    // Low drives tdo.
);
    import pdc_pkg::*;

    typedef struct packed {
        logic [CELLS-1:0]    io_s1, io_s2, io_s3, io_f;
        logic [2:0]          jt_s1, jt_s2, jt_s3, jt_f;
        logic                pd;
        logic [CELLS-1:0]    in_hold, cell_q, io_out, io_oe;
        logic [SETTLE_W-1:0] settle;
        logic                ready;
        logic [CTRL_W-1:0]   ctrl;
        logic [CELLS-1:0]    low_power, slew_fast, out_en, out_pol;
        logic [SIG_W-1:0]    signature;
        logic                fuse, refused;
        logic [MEM_AW-1:0]   cfg_addr;
        logic                aw_got, w_got;
        logic [7:0]          aw_l;
        logic [31:0]         w_l;
        logic [3:0]          strb_l;
        logic                bvalid, rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        tap_state_t          tap;
        logic [1:0]          ir, ir_sh;
        logic [31:0]         dr;
        logic                tdo;
    } state_t;

    state_t      r;
    state_t      next_r;
    logic [31:0] mem_rdata;
    logic        mem_we;
    logic        pd_req;
    logic        tck_rise;
    logic [CELLS-1:0] dedicated;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        if (a[1:0] != 2'h0 || a > LAST_OFFSET)
            return IDX_NONE;
        else
            return a[5:2];
    endfunction : reg_index

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                m[i*8 +: 8] = nw[i*8 +: 8];
        return m;
    endfunction : merge

    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic m);
        case (s)
            TAP_RESET:      return m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:       return m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:     return m ? TAP_SEL_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR:   return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR:   return m ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR:   return m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR:   return m ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR:  return m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:     return m ? TAP_RESET : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR:   return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR:   return m ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR:   return m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR:   return m ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR:  return m ? TAP_SEL_DR : TAP_IDLE;
            default:        return TAP_RESET;
        endcase
    endfunction : tap_next

    // ------------------------------------------------------------------
    // Combinational terms
    // ------------------------------------------------------------------
    assign pd_req = r.ctrl[CTRL_PD_EN]
                  & ((r.ctrl[CTRL_USE_A] & r.io_f[PIN_A])
                  |  (r.ctrl[CTRL_USE_B] & r.io_f[PIN_B]));
    assign dedicated = {{(CELLS-2){1'b0}},
                        r.ctrl[CTRL_PD_EN] & r.ctrl[CTRL_USE_B],
                        r.ctrl[CTRL_PD_EN] & r.ctrl[CTRL_USE_A]};
    assign tck_rise = ~r.pd & r.jt_s2[JT_TCK] & r.jt_s3[JT_TCK]
                    & ~r.jt_f[JT_TCK];
    assign mem_we = r.aw_got & r.w_got
                  & (reg_index(r.aw_l) == IDX_CFG_DATA);
    assign awready = ~r.aw_got & ~r.bvalid;
    assign wready  = ~r.w_got & ~r.bvalid;
    assign arready = ~r.rvalid;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [3:0]  widx;
        logic [31:0] rv;
        logic        rise;
        widx = reg_index(r.aw_l);
        rv = '0;
        rise = 1'b0;
        next_r = r;

        // A pin level counts once the second and third stages agree.
        next_r.io_s1 = io_in;
        next_r.io_s2 = r.io_s1;
        next_r.io_s3 = r.io_s2;
        next_r.io_f  = (r.io_s2 & r.io_s3) | (r.io_f & (r.io_s2 | r.io_s3));
        next_r.jt_s1 = {tdi, tms, tck};
        next_r.jt_s2 = r.jt_s1;
        next_r.jt_s3 = r.jt_s2;
        // JTAG pins freeze with the rest while powered down.
        if (!r.pd)
        begin
            next_r.jt_f = (r.jt_s2 & r.jt_s3)
                        | (r.jt_f & (r.jt_s2 | r.jt_s3));
            rise = tck_rise;
        end

        // Settling interval after reset release; cells capture nothing
        // until it ends, so the first clock edge lands on settled data.
        if (!r.ready)
        begin
            next_r.settle = r.settle + SETTLE_W'(1);
            if (r.settle == SETTLE_W'(SETTLE_CYC - 1))
                next_r.ready = 1'b1;
        end

        next_r.pd = pd_req;
        if (!r.pd)
        begin
            next_r.in_hold = r.io_f;
            if (r.ready)
                next_r.cell_q = core_d;
            next_r.io_out = next_r.cell_q ^ r.out_pol;
            next_r.io_oe  = ~r.out_en | dedicated;
        end

        // AXI4-Lite write: address and data taken in either order.
        if (awvalid && awready)
        begin
            next_r.aw_got = 1'b1;
            next_r.aw_l   = awaddr;
        end
        if (wvalid && wready)
        begin
            next_r.w_got  = 1'b1;
            next_r.w_l    = wdata;
            next_r.strb_l = wstrb;
        end
        if (r.bvalid && bready)
            next_r.bvalid = 1'b0;
        if (r.aw_got && r.w_got)
        begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            if (widx == IDX_CTRL)
                next_r.ctrl = CTRL_W'(merge(32'(r.ctrl), r.w_l, r.strb_l));
            else if (widx == IDX_STATUS)
            begin
                if (r.strb_l[0] && r.w_l[ST_REFUSED])
                    next_r.refused = 1'b0;
            end
            else if (widx == IDX_LOW_POWER)
                next_r.low_power = merge(r.low_power, r.w_l, r.strb_l);
            else if (widx == IDX_SLEW_FAST)
                next_r.slew_fast = merge(r.slew_fast, r.w_l, r.strb_l);
            else if (widx == IDX_OUT_EN)
                next_r.out_en = merge(r.out_en, r.w_l, r.strb_l);
            else if (widx == IDX_OUT_POL)
                next_r.out_pol = merge(r.out_pol, r.w_l, r.strb_l);
            else if (widx == IDX_SIGNATURE)
                next_r.signature = SIG_W'(merge(32'(r.signature),
                                                r.w_l, r.strb_l));
            else if (widx == IDX_FUSE)
            begin
                if (r.strb_l[0] && r.w_l[FUSE_PROG])
                    next_r.fuse = 1'b1;
            end
            else if (widx == IDX_CFG_ADDR)
                next_r.cfg_addr = MEM_AW'(merge(32'(r.cfg_addr),
                                                r.w_l, r.strb_l));
        end

        // AXI4-Lite read.
        if (r.rvalid && rready)
            next_r.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = RESP_OKAY;
            if (reg_index(araddr) == IDX_CTRL)
                rv = 32'(r.ctrl);
            else if (reg_index(araddr) == IDX_STATUS)
            begin
                rv[ST_PD]      = r.pd;
                rv[ST_FUSE]    = r.fuse;
                rv[ST_READY]   = r.ready;
                rv[ST_REFUSED] = r.refused;
            end
            else if (reg_index(araddr) == IDX_LOW_POWER)
                rv = r.low_power;
            else if (reg_index(araddr) == IDX_SLEW_FAST)
                rv = r.slew_fast;
            else if (reg_index(araddr) == IDX_OUT_EN)
                rv = r.out_en;
            else if (reg_index(araddr) == IDX_OUT_POL)
                rv = r.out_pol;
            else if (reg_index(araddr) == IDX_SIGNATURE)
                rv = 32'(r.signature);
            else if (reg_index(araddr) == IDX_FUSE)
                rv = 32'(r.fuse);
            else if (reg_index(araddr) == IDX_CFG_ADDR)
                rv = 32'(r.cfg_addr);
            else if (reg_index(araddr) == IDX_CFG_DATA)
            begin
                if (r.fuse)
                begin
                    next_r.rresp   = RESP_SLVERR;
                    next_r.refused = 1'b1;
                end
                else
                    rv = mem_rdata;
            end
            else
                next_r.rresp = RESP_SLVERR;
            next_r.rdata = rv;
        end

        // Test access port, stepped on each filtered tck rise.
        if (rise)
        begin
            next_r.tap = tap_next(r.tap, r.jt_f[JT_TMS]);
            case (r.tap)
                TAP_RESET:
                    next_r.ir = IR_BYPASS;
                TAP_CAPTURE_IR:
                    next_r.ir_sh = IR_CAPTURE;
                TAP_SHIFT_IR:
                    next_r.ir_sh = {r.jt_f[JT_TDI], r.ir_sh[1]};
                TAP_UPDATE_IR:
                    next_r.ir = r.ir_sh;
                TAP_CAPTURE_DR:
                begin
                    next_r.dr = '0;
                    if (r.ir == IR_SIG)
                        next_r.dr = 32'(r.signature);
                    else if (r.ir == IR_VERIFY)
                    begin
                        if (r.fuse)
                            next_r.refused = 1'b1;
                        else
                            next_r.dr = mem_rdata;
                    end
                end
                TAP_SHIFT_DR:
                    next_r.dr = {r.jt_f[JT_TDI], r.dr[31:1]};
                default:
                    next_r.dr = r.dr;
            endcase
            next_r.tdo = (r.tap == TAP_SHIFT_IR || r.tap == TAP_CAPTURE_IR)
                       ? next_r.ir_sh[0] : next_r.dr[0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r       <= '0;
            r.io_oe <= '1;
            r.tap   <= TAP_RESET;
            r.ir    <= IR_BYPASS;
        end
        else
        begin
            r <= next_r;
        end
    end

    cfg_mem u_cfg_mem
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (mem_we),
        .addr    (r.cfg_addr),
        .wdata   (r.w_l),
        .rdata   (mem_rdata)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bresp          = RESP_OKAY;
    assign bvalid         = r.bvalid;
    assign rdata          = r.rdata;
    assign rresp          = r.rresp;
    assign rvalid         = r.rvalid;
    assign io_out         = r.io_out;
    assign io_oe          = r.io_oe;
    assign slew_fast      = r.slew_fast;
    assign cell_low_power = r.low_power;
    assign logic_in       = r.in_hold & ~dedicated;
    assign buried_fb      = r.cell_q;
    assign freeze         = r.pd;
    assign tdo_out        = r.tdo;
    assign tdo_oe         = ~(r.tap == TAP_SHIFT_DR || r.tap == TAP_SHIFT_IR);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pd_enter: assert property (pd_req |=> r.pd)
        else $error("power-down not entered");
    a_freeze_outputs: assert property
        (r.pd |=> $stable(io_out) && $stable(io_oe))
        else $error("outputs moved while powered down");
    a_inputs_ignored: assert property
        (r.pd |=> $stable(r.in_hold) && $stable(r.tap))
        else $error("input change seen while powered down");
    a_pin_dedicated: assert property
        (dedicated[PIN_A] && !r.pd |-> !logic_in[PIN_A] ##1 io_oe[PIN_A])
        else $error("power-down pin used as logic");
    a_foldback_live: assert property
        (r.ready && !r.pd |=> buried_fb == $past(core_d))
        else $error("cell feedback not updated");
    a_low_power_off: assert property
        ($rose(aresetn) |-> cell_low_power == '0)
        else $error("reduced-power default not off");
    a_slew_slow: assert property
        ($rose(aresetn) |-> slew_fast == '0)
        else $error("slew default not slow");
    a_reset_level: assert property
        (!r.ready && $stable(r.out_pol) |-> io_out == r.out_pol)
        else $error("output not at polarity level after reset");
    a_verify_blocked: assert property
        (r.fuse && r.ir == IR_VERIFY && r.tap == TAP_CAPTURE_DR
         && next_r.tap != r.tap |=> r.dr == '0 && r.refused)
        else $error("verify read while fuse programmed");
    a_sig_readable: assert property
        (arvalid && arready && reg_index(araddr) == IDX_SIGNATURE
         |=> rvalid && rdata == 32'($past(r.signature)))
        else $error("signature read wrong");
    a_pd_exit: assert property
        (r.pd && !pd_req |=> !r.pd)
        else $error("power-down not left with both pins low");

    c_pd_cycle: cover property (!r.pd ##1 r.pd ##[1:50] !r.pd);
    c_axi_write: cover property (bvalid && bready);
    c_verify_refused: cover property ($rose(r.refused));
    c_tap_shift: cover property (r.tap == TAP_SHIFT_DR);

endmodule : power_down_and_config_control

// ==== board_model.sv ====
// Board-side model driving the power-down pins and the programmer's JTAG levels.
`timescale 1ns/1ps
module board_model
(
    input  wire logic [1:0]  pd_req,  // Power-down pin levels.
    input  wire logic [29:0] user_in, // Ordinary pin levels.
    input  wire logic [2:0]  jtag_drv, // Programmer {tdi, tms, tck}.
    output logic      [31:0] pins,    // Device pins.
    output logic             tck,     // JTAG clock.
    output logic             tms,     // JTAG mode.
    output logic             tdi      // JTAG data.
);
    // Pins change only right after a bench clock edge, so inputs are settled.
    assign pins = {user_in, pd_req};
    // The programmer holds tck high between steps; before the first it sits low with
    // tms and tdi high, as their pull-ups would leave them.
    assign tck = jtag_drv[0];
    assign tms = jtag_drv[1];
    assign tdi = jtag_drv[2];
endmodule : board_model

// ==== power_down_and_config_control_tb.sv ====
// Self-checking bench for the power-down and configuration block.
`timescale 1ns/1ps
module power_down_and_config_control_tb;
    import pdc_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic        rvalid, freeze, tdo_out, tdo_oe, tck, tms, tdi;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, core_d = 0, rdata, io_in, io_out, io_oe, q;
    logic [31:0] slew_fast, cell_low_power, logic_in, buried_fb, v, s, hold;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, r, pd_req = 0;
    logic [29:0] user_in = 0;
    logic [2:0]  jtag_drv = 3'h6;
    logic [15:0] o16;
    int          bad_count = 0, n_tests = 0;
    always #2 aclk = ~aclk;
    board_model PM (.pd_req(pd_req), .user_in(user_in), .pins(io_in),
        .jtag_drv(jtag_drv), .tck(tck), .tms(tms), .tdi(tdi));
    power_down_and_config_control DUT (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .slew_fast(slew_fast), .logic_in(logic_in),
        .cell_low_power(cell_low_power), .core_d(core_d), .tck(tck),
        .buried_fb(buried_fb), .freeze(freeze), .tms(tms), .tdi(tdi),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wt(input int c);
        repeat (c) @(posedge aclk);
        @(negedge aclk);
    endtask : wt
    function automatic logic [31:0] pin_level(input logic [31:0] c,
                                              input logic [31:0] p);
        return c ^ p;
    endfunction : pin_level
    // One programmer step: tms and tdi settle well before tck rises.
    task automatic jt(input bit m, input bit d);
        @(posedge aclk);
        jtag_drv <= {d, m, 1'b0};
        repeat (4) @(posedge aclk);
        jtag_drv[0] <= 1'b1;
        repeat (5) @(posedge aclk);
    endtask : jt
    // From Run-Test/Idle: load an instruction, capture, shift 16 bits.
    task automatic jread(input logic [1:0] ins, output logic [15:0] o);
        int k;
        jt(1, 1);
        jt(1, 1);
        jt(0, 1);
        jt(0, 1);
        jt(0, ins[0]);
        jt(1, ins[1]);
        jt(1, 1);
        jt(1, 1);
        jt(0, 1);
        jt(0, 1);
        check({31'h0, tdo_oe}, 32'h0);
        for (k = 0; k < 16; k++)
        begin
            o[k] = tdo_out;
            jt(k >= 14, 1);
        end
        jt(0, 1);
    endtask : jread
    // One write or one read; handshakes are sampled just before each edge.
    task automatic bus(input bit w, input logic [7:0] a,
                       input logic [31:0] d);
        logic ka, kw, kr, kb;
        int   n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        araddr  <= a;
        wdata   <= d;
        awvalid <= w;
        wvalid  <= w;
        bready  <= w;
        arvalid <= !w;
        rready  <= !w;
        do
        begin
            @(negedge aclk);
            ka = awready;
            kw = wready;
            kr = arready;
            kb = w ? bvalid : rvalid;
            q  = rdata;
            r  = w ? bresp : rresp;
            @(posedge aclk);
            if (ka) awvalid <= 1'b0;
            if (kw) wvalid <= 1'b0;
            if (kr) arvalid <= 1'b0;
            if (kb) bready <= 1'b0;
            if (kb) rready <= 1'b0;
            if (n++ > 100)
            begin
                bad_count++;
                print_verdict();
            end
        end while (!kb);
    endtask : bus
    initial
    begin
        int i;
        void'($urandom(42921));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wt(1);
        check(io_oe, 32'hFFFFFFFF);
        check(slew_fast, 32'h0);
        check(cell_low_power, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            bus(1, 8'h0C, v);
            bus(1, 8'h08, ~v);
            wt(3);
            check(slew_fast, v);
            check(cell_low_power, ~v);
        end
        wt(50);
        bus(1, 8'h00, 32'h7);
        core_d  <= $urandom;
        user_in <= 30'($urandom);
        pd_req  <= 2'b01;
        for (i = 0; i < 20 && freeze !== 1'b1; i++) @(negedge aclk);
        check({31'h0, freeze}, 32'h1);
        check(logic_in & 32'h3, 32'h0);
        hold = buried_fb;
        v = logic_in;
        @(posedge aclk);
        core_d  <= ~core_d;
        user_in <= ~user_in;
        pd_req  <= 2'b11;
        wt(10);
        check(buried_fb, hold);
        check(logic_in, v);
        @(posedge aclk);
        pd_req <= 2'b10;
        s = $urandom;
        bus(1, 8'h14, s);
        wt(10);
        check({31'h0, freeze}, 32'h1);
        check(io_out, pin_level(hold, 32'h0));
        @(posedge aclk);
        pd_req <= 2'b00;
        wt(10);
        check({31'h0, freeze}, 32'h0);
        check(buried_fb, core_d);
        check(io_out, pin_level(core_d, s));
        s = $urandom & 32'hFFFF;
        bus(1, 8'h18, s);
        v = $urandom | 32'h1;
        bus(1, 8'h24, v);
        wt(2);
        bus(0, 8'h24, 32'h0);
        check(q, v);
        bus(1, 8'h1C, 32'h1);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        bus(0, 8'h24, 32'h0);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        check(q, 32'h0);
        bus(0, 8'h18, 32'h0);
        check(q, s);
        jt(0, 1);
        jread(IR_SIG, o16);
        check({16'h0, o16}, s);
        jread(IR_VERIFY, o16);
        check({16'h0, o16}, 32'h0);
        print_verdict();
    end
endmodule : power_down_and_config_control_tb
